// file: design/pia_pkg.sv
// package: constants and types of the priority interrupt arbiter
package pia_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NSRC       = 33;
  localparam int NCHAN      = 8;
  localparam int ADDR_W     = 12;

  // ************************************************************
  // source control register layout (low byte)
  // ************************************************************
  localparam int GROUP_LEVEL_FIELD_LO    = 0;
  localparam int GROUP_LEVEL_FIELD_HI    = 1;
  localparam int PRIORITY_LEVEL_FIELD_LO    = 2;
  localparam int PRIORITY_LEVEL_FIELD_HI    = 5;
  localparam int SRC_EN_BIT = 6;
  localparam int FLAG_BIT   = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] XFER_LVL_MIN = 4'hE;

  // ************************************************************
  // processor status word layout
  // ************************************************************
  localparam int PSW_PRIORITY_LEVEL_FIELD_LO = 12;
  localparam int PSW_IEN_BIT = 11;
  localparam logic [3:0] PRIORITY_LEVEL_FIELD_RESET = 4'h0;
  localparam logic       IEN_RESET  = 1'b0;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] SRC_BASE   = 12'h000;
  localparam logic [ADDR_W-1:0] SRC_LAST   = 12'h080;
  localparam logic [ADDR_W-1:0] PSW_OFF    = 12'h100;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h104;

  typedef enum logic [1:0] {
    PIA_IDLE     = 2'b00,
    PIA_CPU_REQ  = 2'b01,
    PIA_XFER_REQ = 2'b10
  } pia_fsm_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } pia_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pia_apb_rsp_t;

  typedef struct packed {
    logic [NSRC-1:0][7:0] ctl;
    logic [3:0]           priority_level_field;
    logic                 global_request_enable;
    pia_fsm_t             fsm;
    logic [5:0]           sel;
    logic [3:0]           sel_lvl;
    logic [2:0]           chan;
    logic                 cpu_req;
    logic                 xfer_req;
    logic                 stack_push;
    logic [15:0]          stack_psw;
    logic                 wake;
    pia_apb_rsp_t         apb;
  } pia_state_t;

endpackage

// file: design/pia_top.sv
// priority interrupt arbiter: source control registers, arbitration and routing
//
// Contract
// - upper byte of each source control register reads zero, writes discarded
// - whole low byte of each source control register is software read/write
// - thirty-three sources, each with its own control register
// - sources sharing a node share its level and enable; handler arbitrates
// - priority level ranks numerically, 0 lowest, 15 highest
// - equal priority requests are ordered by group level, 3 highest
// - source enable 0 blocks the request, 1 allows it
// - acceptance needs source settings and global enable and CPU level
// - hardware sets the request flag on each source event
// - flag clears on CPU service entry or on a transfer service
// - transfer whose count reaches zero leaves the flag set
// - software set or clear of a flag acts like hardware
// - serviced only above CPU level; on CPU entry old status pushed, level loaded
// - nesting up to fifteen levels; level zero never wins
// - levels 15 and 14 go to a transfer channel unless count is zero
// - levels 13 to 1 always become CPU interrupts
// - level zero is never serviced but enabled request wakes the CPU
// - channel is four times level LSB plus group level
// - simultaneous channel requests: higher channel number wins
// - at each instruction end while idle, one highest pending request is chosen
// - global enable clear stops new acceptance; pending work completes
`timescale 1ns/1ps

module pia_top (
  input  wire logic                   clk_i,              // 200 MHz clock
  input  wire logic                   resetn_i,           // async reset, active low
  input  wire pia_pkg::pia_apb_req_t  apb_i,              // apb request
  output pia_pkg::pia_apb_rsp_t       apb_o,              // apb response
  input  wire logic [32:0]            src_event_i,        // per-source request pulses
  input  wire logic                   instr_end_i,        // end of instruction cycle
  input  wire logic                   cpu_ack_i,          // cpu enters service routine
  input  wire logic                   cpu_reti_i,         // return, restore status word
  input  wire logic [15:0]            reti_psw_i,         // status word popped from stack
  input  wire logic [7:0]             chan_count_zero_i,  // channel count field is zero
  input  wire logic                   xfer_done_i,        // transfer service performed
  input  wire logic                   xfer_count_zero_i,  // count decremented to zero
  output logic                        cpu_req_o,          // vectored interrupt request
  output logic [5:0]                  cpu_vec_o,          // winning source index
  output logic [3:0]                  cpu_lvl_o,          // winning priority level
  output logic                        xfer_req_o,         // transfer channel request
  output logic [2:0]                  xfer_chan_o,        // selected channel
  output logic [5:0]                  xfer_src_o,         // source served by transfer
  output logic                        stack_push_o,       // push old status word
  output logic [15:0]                 stack_psw_o,        // status word to push
  output logic [3:0]                  cpu_priority_level_field_o,         // current cpu level
  output logic                        cpu_ien_o,          // global request enable
  output logic                        wake_o              // leave idle mode
);

  // ************************************************************
  // state
  // ************************************************************
  pia_pkg::pia_state_t st;
  pia_pkg::pia_state_t next_st;

  logic [5:0] best_key;
  logic [5:0] best_idx;
  logic       found;
  logic       acc;
  logic       done;
  logic       src_hit;
  logic       psw_hit;
  logic       stat_hit;
  logic [5:0] widx;

  always_comb begin
    next_st  = st;
    best_key = 6'h00;
    best_idx = 6'h00;
    found    = 1'b0;
    next_st.stack_push = 1'b0;
    next_st.wake       = 1'b0;

    // ************************************************************
    // apb decode; one wait state so read data comes from a flop
    // ************************************************************
    acc      = apb_i.psel & apb_i.penable;
    done     = acc & st.apb.pready;
    widx     = apb_i.paddr[7:2];
    src_hit  = (apb_i.paddr <= pia_pkg::SRC_LAST) && (apb_i.paddr[1:0] == 2'h0);
    psw_hit  = apb_i.paddr == pia_pkg::PSW_OFF;
    stat_hit = apb_i.paddr == pia_pkg::STATUS_OFF;
    next_st.apb.pready = acc & ~st.apb.pready;
    if (acc && !st.apb.pready) begin
      next_st.apb.pslverr = ~(src_hit | psw_hit | stat_hit);
      next_st.apb.prdata  = 32'h0000_0000;
      if (src_hit) begin
        next_st.apb.prdata = {24'h00_0000, st.ctl[widx]};
      end else if (psw_hit) begin
        next_st.apb.prdata = {16'h0000, st.priority_level_field, st.global_request_enable, 11'h000};
      end else if (stat_hit) begin
        next_st.apb.prdata = {22'h00_0000, st.fsm, 2'h0, st.sel};
      end
    end

    // ************************************************************
    // per-source control: software write, service clear, event set
    // ************************************************************
    for (int i = 0; i < pia_pkg::NSRC; i++) begin
      // only the low byte lane lands; the reserved byte is dropped
      if (done && apb_i.pwrite && src_hit && widx == 6'(i) && apb_i.pstrb[0]) begin
        next_st.ctl[i] = apb_i.pwdata[7:0];
      end
      if (st.fsm == pia_pkg::PIA_CPU_REQ && cpu_ack_i && st.sel == 6'(i)) begin
        next_st.ctl[i][pia_pkg::FLAG_BIT] = 1'b0;
      end
      if (st.fsm == pia_pkg::PIA_XFER_REQ && xfer_done_i && st.sel == 6'(i)
          && !xfer_count_zero_i) begin
        next_st.ctl[i][pia_pkg::FLAG_BIT] = 1'b0;
      end
      // a fresh event beats any clear in the same cycle
      if (src_event_i[i]) begin
        next_st.ctl[i][pia_pkg::FLAG_BIT] = 1'b1;
      end
      if (st.ctl[i][pia_pkg::FLAG_BIT] && st.ctl[i][pia_pkg::SRC_EN_BIT]) begin
        next_st.wake = 1'b1;
        // key is {level, group}: level ranks first, group breaks ties
        if (st.ctl[i][pia_pkg::PRIORITY_LEVEL_FIELD_HI:pia_pkg::PRIORITY_LEVEL_FIELD_LO] != 4'h0
            && st.ctl[i][pia_pkg::PRIORITY_LEVEL_FIELD_HI:0] > best_key) begin
          best_key = st.ctl[i][pia_pkg::PRIORITY_LEVEL_FIELD_HI:0];
          best_idx = 6'(i);
          found    = 1'b1;
        end
      end
    end

    // ************************************************************
    // processor status word: software, return, then service entry
    // ************************************************************
    if (done && apb_i.pwrite && psw_hit && apb_i.pstrb[1]) begin
      next_st.priority_level_field = apb_i.pwdata[pia_pkg::PSW_PRIORITY_LEVEL_FIELD_LO +: 4];
      next_st.global_request_enable  = apb_i.pwdata[pia_pkg::PSW_IEN_BIT];
    end
    if (cpu_reti_i) begin
      next_st.priority_level_field = reti_psw_i[pia_pkg::PSW_PRIORITY_LEVEL_FIELD_LO +: 4];
      next_st.global_request_enable  = reti_psw_i[pia_pkg::PSW_IEN_BIT];
    end

    // ************************************************************
    // arbitration and routing
    // ************************************************************
    unique case (st.fsm)
      pia_pkg::PIA_IDLE: begin
        // global enable only gates new acceptance; a held request still finishes
        if (instr_end_i && st.global_request_enable && found
            && best_key[5:2] > st.priority_level_field) begin
          next_st.sel     = best_idx;
          next_st.sel_lvl = best_key[5:2];
          next_st.chan    = best_key[2:0];
          if (best_key[5:2] >= pia_pkg::XFER_LVL_MIN
              && !chan_count_zero_i[best_key[2:0]]) begin
            next_st.fsm      = pia_pkg::PIA_XFER_REQ;
            next_st.xfer_req = 1'b1;
          end else begin
            next_st.fsm     = pia_pkg::PIA_CPU_REQ;
            next_st.cpu_req = 1'b1;
          end
        end
      end
      pia_pkg::PIA_CPU_REQ: begin
        if (cpu_ack_i) begin
          next_st.stack_psw  = {st.priority_level_field, st.global_request_enable, 11'h000};
          next_st.stack_push = 1'b1;
          next_st.priority_level_field       = st.sel_lvl;
          next_st.cpu_req    = 1'b0;
          next_st.fsm        = pia_pkg::PIA_IDLE;
        end else if (!(st.ctl[st.sel][pia_pkg::FLAG_BIT]
                       && st.ctl[st.sel][pia_pkg::SRC_EN_BIT])) begin
          next_st.cpu_req = 1'b0;
          next_st.fsm     = pia_pkg::PIA_IDLE;
        end
      end
      pia_pkg::PIA_XFER_REQ: begin
        // a transfer steals a cycle and leaves the cpu level alone
        if (xfer_done_i) begin
          next_st.xfer_req = 1'b0;
          next_st.fsm      = pia_pkg::PIA_IDLE;
        end
      end
      default: begin
        next_st.fsm      = pia_pkg::PIA_IDLE;
        next_st.cpu_req  = 1'b0;
        next_st.xfer_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.ctl        <= {pia_pkg::NSRC{pia_pkg::CTL_RESET}};
      st.priority_level_field       <= pia_pkg::PRIORITY_LEVEL_FIELD_RESET;
      st.global_request_enable        <= pia_pkg::IEN_RESET;
      st.fsm        <= pia_pkg::PIA_IDLE;
      st.sel        <= 6'h00;
      st.sel_lvl    <= 4'h0;
      st.chan       <= 3'h0;
      st.cpu_req    <= 1'b0;
      st.xfer_req   <= 1'b0;
      st.stack_push <= 1'b0;
      st.stack_psw  <= 16'h0000;
      st.wake       <= 1'b0;
      st.apb        <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign apb_o        = st.apb;
  assign cpu_req_o    = st.cpu_req;
  assign cpu_vec_o    = st.sel;
  assign cpu_lvl_o    = st.sel_lvl;
  assign xfer_req_o   = st.xfer_req;
  assign xfer_chan_o  = st.chan;
  assign xfer_src_o   = st.sel;
  assign stack_push_o = st.stack_push;
  assign stack_psw_o  = st.stack_psw;
  assign cpu_priority_level_field_o   = st.priority_level_field;
  assign cpu_ien_o    = st.global_request_enable;
  assign wake_o       = st.wake;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_apb_setup;
    apb_i.psel && !apb_i.penable;
  endsequence

  sequence s_apb_access;
    apb_i.psel && apb_i.penable && !apb_o.pready;
  endsequence

  sequence s_cpu_entry;
    st.fsm == pia_pkg::PIA_CPU_REQ && cpu_ack_i && !cpu_reti_i;
  endsequence

  sequence s_accept;
    st.fsm == pia_pkg::PIA_IDLE && instr_end_i;
  endsequence

  AST_APB_READY: assert property (s_apb_setup ##1 s_apb_access |=> apb_o.pready)
    else $error("apb ready not one cycle after access");

  AST_RSVD_ZERO: assert property (apb_o.pready |-> apb_o.prdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");

  AST_EVENT_SET: assert property (src_event_i[0] |=> st.ctl[0][pia_pkg::FLAG_BIT])
    else $error("source event did not set flag");

  AST_ENTRY_PSW: assert property (s_cpu_entry |=> stack_push_o
      && cpu_priority_level_field_o == $past(cpu_lvl_o)
      && stack_psw_o[15:12] == $past(cpu_priority_level_field_o))
    else $error("service entry did not push and load level");

  AST_ENTRY_CLR: assert property ((s_cpu_entry and (!src_event_i[st.sel]))
      |=> !st.ctl[$past(st.sel)][pia_pkg::FLAG_BIT])
    else $error("flag not cleared on service entry");

  AST_IEN_GATE: assert property ((s_accept and (!st.global_request_enable)) |=> st.fsm == pia_pkg::PIA_IDLE)
    else $error("request accepted with global enable clear");

  AST_ABOVE_CPU: assert property ($rose(cpu_req_o) |-> cpu_lvl_o > $past(cpu_priority_level_field_o)
      && cpu_lvl_o != 4'h0)
    else $error("request not above cpu level");

  AST_XFER_ROUTE: assert property ($rose(xfer_req_o) |-> cpu_lvl_o[3:1] == 3'b111
      && xfer_chan_o == {cpu_lvl_o[0], st.ctl[xfer_src_o][1:0]})
    else $error("transfer route or channel wrong");

  AST_LOW_CPU: assert property ($rose(cpu_req_o) && cpu_lvl_o < pia_pkg::XFER_LVL_MIN
      |-> !xfer_req_o)
    else $error("low level request sent to transfer channel");

  AST_LAST_KEEP: assert property (st.fsm == pia_pkg::PIA_XFER_REQ && xfer_done_i
      && xfer_count_zero_i && st.ctl[st.sel][pia_pkg::FLAG_BIT]
      |=> st.ctl[$past(st.sel)][pia_pkg::FLAG_BIT])
    else $error("flag lost when count reached zero");

  AST_WAKE: assert property (st.ctl[0][pia_pkg::FLAG_BIT]
      && st.ctl[0][pia_pkg::SRC_EN_BIT] |=> wake_o)
    else $error("enabled request did not wake");

  AST_BEST: assert property ((s_accept and (st.global_request_enable && found && best_key[5:2] > st.priority_level_field))
      |=> cpu_vec_o == $past(best_idx) && (cpu_req_o || xfer_req_o))
    else $error("winner not taken");

  // ************************************************************
  // service, gating and bus checks
  // ************************************************************

  sequence s_xfer_done;
    st.fsm == pia_pkg::PIA_XFER_REQ && xfer_done_i;
  endsequence

  sequence s_cpu_wait;
    st.fsm == pia_pkg::PIA_CPU_REQ && !cpu_ack_i
      && st.ctl[st.sel][pia_pkg::FLAG_BIT] && st.ctl[st.sel][pia_pkg::SRC_EN_BIT];
  endsequence

  sequence s_sw_src_write;
    done && apb_i.pwrite && src_hit && apb_i.pstrb[0];
  endsequence

  AST_ONE_ROUTE: assert property (!(cpu_req_o && xfer_req_o))
    else $error("cpu and transfer requests raised together");

  AST_NO_ZERO: assert property ((cpu_req_o || xfer_req_o)
      |-> cpu_lvl_o != 4'h0)
    else $error("level zero request issued");

  AST_XFER_CLR: assert property ((s_xfer_done
      and (!xfer_count_zero_i && !src_event_i[st.sel]))
      |=> !st.ctl[$past(st.sel)][pia_pkg::FLAG_BIT])
    else $error("flag not cleared by transfer service");

  AST_XFER_LVL: assert property ((s_xfer_done and (!cpu_reti_i && !done))
      |=> cpu_priority_level_field_o == $past(cpu_priority_level_field_o) && !xfer_req_o)
    else $error("transfer service touched cpu level or kept request");

  AST_HOLD_REQ: assert property (s_cpu_wait
      |=> cpu_req_o && cpu_vec_o == $past(cpu_vec_o))
    else $error("pending cpu request not held");

  AST_PUSH_ONCE: assert property (stack_push_o |=> !stack_push_o)
    else $error("status push longer than one cycle");

  AST_NOT_FOUND: assert property ((s_accept and (!found))
      |=> st.fsm == pia_pkg::PIA_IDLE)
    else $error("request accepted with no enabled source");

  AST_LVL_GATE: assert property ((s_accept and (found && best_key[5:2] <= st.priority_level_field))
      |=> st.fsm == pia_pkg::PIA_IDLE)
    else $error("request accepted at or below cpu level");

  AST_SW_WRITE: assert property ((s_sw_src_write
      and (st.fsm == pia_pkg::PIA_IDLE && !src_event_i[widx]))
      |=> st.ctl[$past(widx)] == $past(apb_i.pwdata[7:0]))
    else $error("software write to control register lost");

endmodule

// file: dv/pia_far_model.sv
// partner model: cpu core and transfer-channel controller beside the arbiter
`timescale 1ns/1ps

module pia_far_model (
  input  wire logic       clk_i,             // clock
  input  wire logic       resetn_i,          // async reset, active low
  input  wire logic       cpu_req_i,         // vectored request
  input  wire logic       xfer_req_i,        // transfer request
  input  wire logic [3:0] dly_i,             // answer delay in cycles
  input  wire logic [7:0] zero_cfg_i,        // count field zero per channel
  input  wire logic       done_zero_i,       // count hits zero on this transfer
  output logic            cpu_ack_o,         // service routine entered
  output logic            xfer_done_o,       // transfer performed
  output logic            xfer_count_zero_o, // count decremented to zero
  output logic [7:0]      chan_count_zero_o  // count field zero per channel
);
  logic [3:0] cpu_wait;
  logic [3:0] xfer_wait;

  assign chan_count_zero_o = zero_cfg_i;
  // stale outside the done pulse, so show the opposite level there
  assign xfer_count_zero_o = xfer_done_o ? done_zero_i : ~done_zero_i;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_ack_o   <= 1'h0;
      xfer_done_o <= 1'h0;
      cpu_wait    <= 4'h0;
      xfer_wait   <= 4'h0;
    end else begin
      // answer only while the request stands, one pulse each
      cpu_ack_o   <= cpu_req_i && !cpu_ack_o && cpu_wait == dly_i;
      cpu_wait    <= (cpu_req_i && !cpu_ack_o) ? cpu_wait + 4'h1 : 4'h0;
      xfer_done_o <= xfer_req_i && !xfer_done_o && xfer_wait == dly_i;
      xfer_wait   <= (xfer_req_i && !xfer_done_o) ? xfer_wait + 4'h1 : 4'h0;
    end
  end
endmodule

// file: dv/tb_priority_interrupt_arbiter.sv
// self-checking testbench of the priority interrupt arbiter
`timescale 1ns/1ps

module tb_priority_interrupt_arbiter;
  logic                  clk_i, resetn_i, instr_end_i, cpu_ack_i, cpu_reti_i;
  logic                  xfer_done_i, xfer_count_zero_i, done_zero;
  pia_pkg::pia_apb_req_t apb_i;
  pia_pkg::pia_apb_rsp_t apb_o;
  logic [32:0]           src_event_i;
  logic [15:0]           reti_psw_i, stack_psw_o;
  logic [7:0]            chan_count_zero_i, zero_cfg;
  logic                  cpu_req_o, xfer_req_o, stack_push_o, cpu_ien_o, wake_o;
  logic [5:0]            cpu_vec_o, xfer_src_o;
  logic [3:0]            cpu_lvl_o, cpu_priority_level_field_o, dly;
  logic [2:0]            xfer_chan_o;
  int                    num_errors, checked;

  pia_top dut_u (.clk_i, .resetn_i, .apb_i, .apb_o, .src_event_i, .instr_end_i,
    .cpu_ack_i, .cpu_reti_i, .reti_psw_i, .chan_count_zero_i, .xfer_done_i,
    .xfer_count_zero_i, .cpu_req_o, .cpu_vec_o, .cpu_lvl_o, .xfer_req_o, .xfer_chan_o,
    .xfer_src_o, .stack_push_o, .stack_psw_o, .cpu_priority_level_field_o, .cpu_ien_o, .wake_o);

  pia_far_model far_u (.clk_i, .resetn_i, .cpu_req_i(cpu_req_o), .xfer_req_i(xfer_req_o),
    .dly_i(dly), .zero_cfg_i(zero_cfg), .done_zero_i(done_zero), .cpu_ack_o(cpu_ack_i),
    .xfer_done_o(xfer_done_i), .xfer_count_zero_o(xfer_count_zero_i),
    .chan_count_zero_o(chan_count_zero_i));

  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ************************************************************
  // checks and bus tasks
  // ************************************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_port(input logic [15:0] got, input logic [15:0] exp);
    check_val({16'h0, got}, {16'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    @(posedge clk_i);
    apb_i.psel    <= 1'h1;
    apb_i.penable <= 1'h0;
    apb_i.pwrite  <= wr;
    apb_i.paddr   <= addr;
    apb_i.pwdata  <= wdata;
    apb_i.pstrb   <= 4'hF;
    @(posedge clk_i);
    apb_i.penable <= 1'h1;
    do begin
      @(posedge clk_i);
    end while (apb_o.pready !== 1'h1);
    rdata = apb_o.prdata;
    err   = apb_o.pslverr;
    apb_i.psel    <= 1'h0;
    apb_i.penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic        e;
    apb(1'h1, addr, data, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'h0, addr, 32'h0, r, e);
    check_val(r, exp);
    check_port({15'h0, e}, {15'h0, eerr});
  endtask

  // ************************************************************
  // far-side stimulus tasks
  // ************************************************************
  task automatic pulse(input logic [32:0] ev, input logic ie);
    @(posedge clk_i);
    src_event_i <= ev;
    instr_end_i <= ie;
    @(posedge clk_i);
    src_event_i <= 33'h0;
    instr_end_i <= 1'h0;
  endtask

  task automatic reti(input logic [15:0] processor_status_word);
    @(posedge clk_i);
    cpu_reti_i <= 1'h1;
    reti_psw_i <= processor_status_word;
    @(posedge clk_i);
    cpu_reti_i <= 1'h0;
  endtask

  task automatic no_req;
    pulse(33'h0, 1'h1);
    repeat (2) @(posedge clk_i);
    check_port({15'h0, cpu_req_o | xfer_req_o}, 16'h0);
  endtask

  task automatic wait_cpu(input logic [5:0] vec, input logic [3:0] lvl, input logic [15:0] old);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_req_o !== 1'h1 && n < 30);
    check_port({cpu_req_o, xfer_req_o, cpu_vec_o, cpu_lvl_o}, {2'h2, vec, lvl});
    do begin
      @(posedge clk_i);
      n++;
    end while (stack_push_o !== 1'h1 && n < 60);
    check_port({15'h0, stack_push_o}, 16'h1);
    check_port(stack_psw_o, old);
    check_port({12'h0, cpu_priority_level_field_o}, {12'h0, lvl});
  endtask

  task automatic wait_xfer(input logic [2:0] chan, input logic [5:0] src);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (xfer_req_o !== 1'h1 && n < 30);
    check_port({cpu_req_o, xfer_req_o, xfer_chan_o, xfer_src_o}, {2'h1, chan, src});
    do begin
      @(posedge clk_i);
      n++;
    end while (xfer_req_o !== 1'h0 && n < 60);
    check_port({15'h0, xfer_req_o}, 16'h0);
    check_port({12'h0, cpu_priority_level_field_o}, 16'h0);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {resetn_i, instr_end_i, cpu_reti_i, done_zero} = 4'h0;
    {apb_i, src_event_i, reti_psw_i, zero_cfg, dly} = '0;
    num_errors = 0;
    checked = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'h1;
    rd_chk(12'h000, 32'h0, 1'h0);
    rd_chk(12'h080, 32'h0, 1'h0);
    rd_chk(12'h100, 32'h0, 1'h0);
    wr(12'h014, 32'hFFFF_FF7F);
    rd_chk(12'h014, 32'h7F, 1'h0);
    rd_chk(12'h200, 32'h0, 1'h1);
    wr(12'h014, 32'h0);
    wr(12'h100, 32'h0800);
    // equal levels keep distinct groups so the vector stays unique
    wr(12'h00C, 32'h56);
    wr(12'h01C, 32'h57);
    wr(12'h024, 32'h53);
    pulse(33'h288, 1'h0);
    pulse(33'h0, 1'h1);
    wait_cpu(6'h07, 4'h5, 16'h0800);
    rd_chk(12'h01C, 32'h57, 1'h0);
    rd_chk(12'h00C, 32'hD6, 1'h0);
    rd_chk(12'h100, 32'h5800, 1'h0);
    no_req;
    reti(16'h0800);
    dly <= 4'h5;
    pulse(33'h0, 1'h1);
    wait_cpu(6'h03, 4'h5, 16'h0800);
    wr(12'h050, 32'h76);
    pulse(33'h1_0010_0000 ^ 33'h1_0000_0000, 1'h0);
    pulse(33'h0, 1'h1);
    wait_cpu(6'h14, 4'hD, 16'h5800);
    reti(16'h5800);
    reti(16'h0800);
    wr(12'h100, 32'h0);
    no_req;
    wr(12'h100, 32'h0800);
    wr(12'h024, 32'h93);
    no_req;
    check_port({15'h0, wake_o}, 16'h0);
    wr(12'h024, 32'hD3);
    pulse(33'h0, 1'h1);
    wait_cpu(6'h09, 4'h4, 16'h0800);
    reti(16'h0800);
    wr(12'h000, 32'hC3);
    no_req;
    check_port({15'h0, wake_o}, 16'h1);
    wr(12'h000, 32'h43);
    repeat (2) @(posedge clk_i);
    check_port({15'h0, wake_o}, 16'h0);
    pulse(33'h1, 1'h0);
    rd_chk(12'h000, 32'hC3, 1'h0);
    wr(12'h030, 32'h7E);
    wr(12'h034, 32'h7B);
    pulse(33'h3000, 1'h0);
    pulse(33'h0, 1'h1);
    wait_xfer(3'h6, 6'h0C);
    rd_chk(12'h030, 32'h7E, 1'h0);
    done_zero <= 1'h1;
    pulse(33'h0, 1'h1);
    wait_xfer(3'h3, 6'h0D);
    rd_chk(12'h034, 32'hFB, 1'h0);
    zero_cfg <= 8'h08;
    pulse(33'h0, 1'h1);
    wait_cpu(6'h0D, 4'hE, 16'h0800);
    tally_and_finish();
  end
endmodule
